// file: logic/cfg_parity_pkg.sv
// Package with register layout, field positions and timing constants of the parity and output select block.
package cfg_parity_pkg;

	localparam int          REG_W          = 9;
	localparam int          NUM_CFG        = 6;
	localparam int          NUM_REGS       = 8;
	localparam logic [3:0]  ADDR_CFG0      = 4'h0;
	localparam logic [3:0]  ADDR_CFG1      = 4'h1;
	localparam logic [3:0]  ADDR_CFG2      = 4'h2;
	localparam logic [3:0]  ADDR_CFG5      = 4'h5;
	localparam logic [3:0]  ADDR_COLPAR    = 4'h6;
	localparam logic [3:0]  ADDR_STATUS    = 4'h7;
	localparam logic [8:0]  CFG_RESET      = 9'h000;
	localparam int          ROW_PAR_BIT    = 0;
	localparam int          CH_EN_BIT      = 1;
	localparam int          OUT_TYPE_HI    = 8;
	localparam int          OUT_TYPE_LO    = 7;
	localparam int          CLK_DIV_BIT    = 7;
	localparam int          AGC_SIG_BIT    = 7;
	localparam int          READ_PAD_BITS  = 7;
	localparam logic [2:0]  CMD_READ       = 3'h6;
	localparam logic [2:0]  CMD_WRITE      = 3'h7;
	localparam int          SPI_FRAME_BITS = 16;
	localparam int          CLK_DIV_RATIO  = 4;
	localparam real         MCLK_NS        = 4.0;
	localparam real         AGC_INIT_NS    = 4000.0;
	localparam int          AGC_INIT_CYC   = (AGC_INIT_NS / MCLK_NS) < 1.0 ? 1 : int'(AGC_INIT_NS / MCLK_NS + 0.4999);

	typedef enum logic [1:0] {
		OUT_DEMOD = 2'h0,
		OUT_CARRIER_CLOCK_OUTPUT  = 2'h1,
		OUT_RSSI2 = 2'h2,
		OUT_RSSI3 = 2'h3
	} out_type_e;

	typedef struct packed {
		logic wr_en;
		logic [3:0] addr;
		logic [8:0] data;
	} reg_wr_s;

	typedef struct packed {
		logic out_filter_ok;
		logic rssi_gate_ok;
		logic mod_depth_ok;
	} out_gate_s;

endpackage

// file: logic/odd_parity_check.sv
// Odd row and column parity checker over the configuration register map.
`timescale 1ns/100ps
`default_nettype none
module odd_parity_check
	import cfg_parity_pkg::*;
(
	input  wire logic [NUM_CFG+1:0][REG_W-1:0] regs,
	output logic                               ok
);
	logic [REG_W-1:0] col;
	logic             rows_ok;

	always_comb begin
		col     = '0;
		rows_ok = 1'b1;
		for (int i = 0; i <= NUM_CFG; i++) begin
			rows_ok = rows_ok & (^regs[i]);
		end
		// Column parity covers configuration registers and the column register, never status.
		for (int i = 0; i <= NUM_CFG; i++) begin
			col = col ^ regs[i];
		end
		ok = rows_ok & (&col);
	end
endmodule
`default_nettype wire

// file: logic/cfg_parity_out_sel.sv
// Configuration register file with SPI access, parity alert and output pin selection.
`timescale 1ns/100ps
`default_nettype none
// Summary of operation
// - Bit zero is odd row parity of bits 8..1.
// - Column register holds parity of config 0..5.
// - Status register excluded from column parity.
// - All parity is odd.
// - Continuous check pulls alert low on failure while chip select is high.
// - Reset clears registers, so alert asserts.
// - Consistent parity releases alert at once.
// - Parity failure changes no other behaviour.
// - Output only while channel enable set.
// - Type 00 data, 01 clock, 1x RSSI.
// - Cleared type field selects demodulated data.
// - Carrier clock appears after AGC init interval.
// - Divide bit selects carrier by one or four.
// - Filter, strength and depth gate carrier clock too.
// - RSSI disables inactivity, alarm, AGC timers.
// - RSSI selection forces active mode immediately.
// - Chip select low suspends RSSI output.
// - RSSI persists until type field rewritten.
// - Read answer: seven pad, eight data, parity.
// - Column read at 0110, status at 0111.
module cfg_parity_out_sel
	import cfg_parity_pkg::*;
#(
	parameter int AGC_CYC = AGC_INIT_CYC
)(
	input  wire logic             mclk,
	input  wire logic             nrst,
	input  wire logic             cs_n_pin,
	input  wire logic             sclk_pin,
	input  wire logic             sdi_pin,
	input  wire logic             carrier_pin,
	input  wire logic             demod_pin,
	input  wire logic             signal_present_pin,
	input  wire out_gate_s        gate_in,
	output logic                  alert_o,
	output logic                  alert_oe,
	output logic                  lf_output_pin_o,
	output logic                  lf_output_pin_oe,
	output logic                  rssi_enable,
	output logic                  active_mode,
	output logic                  timers_enable,
	output logic [REG_W-1:0]      status_reg
);
	import cfg_parity_pkg::*;

	// ----------------------------------------------------------------
	// Input synchronisers
	// ----------------------------------------------------------------
	logic [6:0] sync1_reg;
	logic [6:0] sync2_reg;
	logic [2:0] gate1_reg;
	logic [2:0] gate2_reg;

	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			// Reset values match the idle pin levels, so no false clock or carrier edge follows reset.
			sync1_reg <= 7'h41;
			sync2_reg <= 7'h41;
			gate1_reg <= 3'h0;
			gate2_reg <= 3'h0;
		end else begin
			sync1_reg <= {cs_n_pin, sclk_pin, sdi_pin, carrier_pin, demod_pin, signal_present_pin, 1'b1};
			sync2_reg <= sync1_reg;
			gate1_reg <= gate_in;
			gate2_reg <= gate1_reg;
		end
	end

	logic cs_n;
	logic sclk;
	logic sdi;
	logic carrier;
	logic demod;
	logic sig_present;
	out_gate_s gate;
	assign cs_n        = sync2_reg[6];
	assign sclk        = sync2_reg[5];
	assign sdi         = sync2_reg[4];
	assign carrier     = sync2_reg[3];
	assign demod       = sync2_reg[2];
	assign sig_present = sync2_reg[1];
	assign gate        = out_gate_s'(gate2_reg);

	// ----------------------------------------------------------------
	// SPI shifter, mode 0: sample on rising edge, shift out on falling
	// ----------------------------------------------------------------
	logic        sclk_d_reg;
	logic [15:0] shift_in_reg;
	logic [4:0]  bit_cnt_reg;
	logic [15:0] shift_out_reg;
	logic        rd_pending_reg;
	logic [3:0]  rd_addr_reg;
	logic        rd_phase_reg;
	reg_wr_s     wr;
	logic        sclk_rise;
	logic        sclk_fall;

	assign sclk_rise = sclk & ~sclk_d_reg;
	assign sclk_fall = ~sclk & sclk_d_reg;

	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			sclk_d_reg   <= 1'b0;
			shift_in_reg <= 16'h0000;
			bit_cnt_reg  <= 5'h00;
		end else begin
			sclk_d_reg <= sclk;
			if (cs_n) begin
				bit_cnt_reg <= 5'h00;
			end else if (sclk_rise) begin
				shift_in_reg <= {shift_in_reg[14:0], sdi};
				bit_cnt_reg  <= (bit_cnt_reg == 5'(SPI_FRAME_BITS - 1)) ? 5'h00 : bit_cnt_reg + 5'h01;
			end
		end
	end

	logic frame_done;
	assign frame_done = !cs_n && sclk_rise && bit_cnt_reg == 5'(SPI_FRAME_BITS - 1);
	logic [15:0] frame;
	assign frame = {shift_in_reg[14:0], sdi};

	assign wr.wr_en = frame_done && !rd_phase_reg && frame[15:13] == CMD_WRITE && frame[12:9] <= ADDR_COLPAR;
	assign wr.addr  = frame[12:9];
	assign wr.data  = frame[8:0];

	// ----------------------------------------------------------------
	// Configuration registers, host supplies the parity bits
	// ----------------------------------------------------------------
	logic [NUM_CFG:0][REG_W-1:0] cfg_reg;

	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			for (int i = 0; i <= NUM_CFG; i++) begin
				cfg_reg[i] <= CFG_RESET;
			end
		end else if (wr.wr_en) begin
			cfg_reg[wr.addr] <= wr.data;
		end
	end

	logic        parity_ok;
	logic [NUM_CFG+1:0][REG_W-1:0] map;
	assign map = {status_reg, cfg_reg};

	odd_parity_check u_chk (
		.regs (cfg_reg_ext(cfg_reg)),
		.ok   (parity_ok)
	);

	function automatic logic [NUM_CFG+1:0][REG_W-1:0] cfg_reg_ext(input logic [NUM_CFG:0][REG_W-1:0] r);
		cfg_reg_ext = {9'h1ff, r};
	endfunction

	// ----------------------------------------------------------------
	// Read path
	// ----------------------------------------------------------------
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			rd_pending_reg <= 1'b0;
			rd_addr_reg    <= 4'h0;
			rd_phase_reg   <= 1'b0;
			shift_out_reg  <= 16'h0000;
		end else begin
			if (frame_done && !rd_phase_reg && frame[15:13] == CMD_READ) begin
				rd_pending_reg <= 1'b1;
				rd_addr_reg    <= frame[12:9];
			end
			if (cs_n) begin
				rd_phase_reg <= rd_pending_reg;
				if (rd_pending_reg) begin
					// Status carries no meaningful parity bit.
					shift_out_reg <= {{READ_PAD_BITS{1'b0}}, map[rd_addr_reg[2:0]]};
				end
			end else if (rd_phase_reg) begin
				rd_pending_reg <= 1'b0;
				if (sclk_fall) begin
					shift_out_reg <= {shift_out_reg[14:0], 1'b0};
				end
				if (frame_done) begin
					rd_phase_reg <= 1'b0;
				end
			end
		end
	end

	// ----------------------------------------------------------------
	// Alert, output type and mode control
	// ----------------------------------------------------------------
	out_type_e otype;
	logic      rssi_sel;
	assign otype    = out_type_e'(cfg_reg[ADDR_CFG1][OUT_TYPE_HI:OUT_TYPE_LO]);
	assign rssi_sel = otype == OUT_RSSI2 || otype == OUT_RSSI3;

	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			alert_o  <= 1'b0;
			alert_oe <= 1'b0;
		end else begin
			// Pin is SCLK input while chip select is low, so the alert only drives when idle.
			alert_o  <= 1'b0;
			alert_oe <= !(cs_n && !parity_ok);
		end
	end

	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			rssi_enable   <= 1'b0;
			active_mode   <= 1'b0;
			timers_enable <= 1'b1;
		end else begin
			rssi_enable   <= rssi_sel && cs_n && cfg_reg[ADDR_CFG0][CH_EN_BIT];
			active_mode   <= rssi_sel || sig_present;
			timers_enable <= !rssi_sel;
		end
	end

	// ----------------------------------------------------------------
	// AGC init interval and carrier divider
	// ----------------------------------------------------------------
	logic [$clog2(AGC_CYC+1)-1:0] agc_cnt_reg;
	logic                         agc_done_reg;
	logic [1:0]                   div_cnt_reg;
	logic                         carrier_d_reg;
	logic                         div_clk_reg;

	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			agc_cnt_reg  <= '0;
			agc_done_reg <= 1'b0;
		end else if (!sig_present || rssi_sel) begin
			agc_cnt_reg  <= '0;
			agc_done_reg <= 1'b0;
		end else if (!agc_done_reg) begin
			agc_cnt_reg  <= agc_cnt_reg + 1'b1;
			agc_done_reg <= agc_cnt_reg == ($bits(agc_cnt_reg))'(AGC_CYC - 1);
		end
	end

	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			carrier_d_reg <= 1'b0;
			div_cnt_reg   <= 2'h0;
			div_clk_reg   <= 1'b0;
		end else begin
			carrier_d_reg <= carrier;
			if (carrier & ~carrier_d_reg) begin
				div_cnt_reg <= div_cnt_reg + 2'h1;
				if (div_cnt_reg[0] == 1'b1) begin
					div_clk_reg <= ~div_clk_reg;
				end
			end
		end
	end

	// ----------------------------------------------------------------
	// Output pin mux; parity state is not consulted here
	// ----------------------------------------------------------------
	logic gates_ok;
	logic carrier_clock_output;
	assign gates_ok = gate.out_filter_ok && gate.mod_depth_ok &&
		(gate.rssi_gate_ok || !cfg_reg[ADDR_CFG5][AGC_SIG_BIT]);
	assign carrier_clock_output = cfg_reg[ADDR_CFG2][CLK_DIV_BIT] ? div_clk_reg : carrier;

	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			lf_output_pin_o  <= 1'b0;
			lf_output_pin_oe <= 1'b1;
		end else if (!cs_n) begin
			lf_output_pin_o  <= shift_out_reg[15];
			lf_output_pin_oe <= !rd_phase_reg;
		end else if (!cfg_reg[ADDR_CFG0][CH_EN_BIT]) begin
			lf_output_pin_o  <= 1'b0;
			lf_output_pin_oe <= 1'b1;
		end else begin
			unique case (otype)
				OUT_DEMOD: begin
					lf_output_pin_o  <= demod && gates_ok;
					lf_output_pin_oe <= 1'b0;
				end
				OUT_CARRIER_CLOCK_OUTPUT: begin
					lf_output_pin_o  <= carrier_clock_output && gates_ok && agc_done_reg;
					lf_output_pin_oe <= 1'b0;
				end
				OUT_RSSI2, OUT_RSSI3: begin
					lf_output_pin_o  <= 1'b0;
					lf_output_pin_oe <= 1'b1;
				end
			endcase
		end
	end

	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			status_reg <= 9'h000;
		end else begin
			status_reg <= {4'h0, agc_done_reg, active_mode, rssi_sel, !parity_ok, 1'b0};
		end
	end
endmodule
`default_nettype wire

// file: test/cfg_parity_properties.sv
// Concurrent checks on the alert and RSSI mode outputs.
`timescale 1ns/100ps
`default_nettype none
module cfg_parity_properties
	import cfg_parity_pkg::*;
(
	input wire logic             mclk,
	input wire logic             nrst,
	input wire logic             cs_n_pin,
	input wire logic             alert_o,
	input wire logic             alert_oe,
	input wire logic             rssi_enable,
	input wire logic             active_mode,
	input wire logic             timers_enable,
	input wire logic [REG_W-1:0] status_reg
);
	default clocking @(posedge mclk); endclocking
	default disable iff (!nrst);
	chk_alert_level: assert property (alert_o == 1'b0)
		else $error("alert data not low");
	chk_alert_low: assert property ((status_reg[1] && cs_n_pin)[*4] |-> !alert_oe)
		else $error("alert not driven on error");
	chk_alert_release: assert property ((!status_reg[1])[*3] |-> alert_oe)
		else $error("alert held without error");
	chk_rssi_timers: assert property (rssi_enable |-> !timers_enable)
		else $error("timers run in rssi mode");
	chk_rssi_active: assert property (status_reg[2] |-> active_mode)
		else $error("rssi without active mode");
	chk_rssi_suspend: assert property ((!cs_n_pin)[*4] |-> !rssi_enable)
		else $error("rssi on during frame");
	chk_rssi_resume: assert property ((status_reg[2] && cs_n_pin)[*6] |-> rssi_enable)
		else $error("rssi not resumed");
	chk_timers_sel: assert property (!timers_enable |-> status_reg[2])
		else $error("timers off outside rssi");
	cover property ($rose(alert_oe));
	cover property ($fell(alert_oe));
	cover property (rssi_enable ##1 !rssi_enable);
endmodule
bind cfg_parity_out_sel cfg_parity_properties chk (.mclk(mclk), .nrst(nrst), .cs_n_pin(cs_n_pin),
	.alert_o(alert_o), .alert_oe(alert_oe), .rssi_enable(rssi_enable), .active_mode(active_mode),
	.timers_enable(timers_enable), .status_reg(status_reg));
`default_nettype wire

// file: test/spi_host_model.sv
// Behavioural SPI host standing in for the external microcontroller.
`timescale 1ns/100ps
`default_nettype none
module spi_host_model (
	input  wire logic mclk,
	input  wire logic sdo,
	output logic      cs_n,
	output logic      sclk,
	output logic      sdi
);
	logic [15:0] rx;
	initial begin
		cs_n = 1'b1;
		sclk = 1'b0;
		sdi = 1'b0;
	end
	// Five cycles a phase keeps clear of the four-cycle delay, synchroniser included, from a falling SCLK edge to read data on the pin.
	task automatic half();
		repeat (5) @(posedge mclk);
	endtask
	// Whole frames only, mode 0, since the device drops partial ones.
	task automatic frame(input logic [15:0] tx);
		cs_n <= 1'b0;
		for (int i = 15; i >= 0; i--) begin
			sdi <= tx[i];
			half();
			rx[i] = sdo;
			sclk <= 1'b1;
			half();
			sclk <= 1'b0;
		end
		half();
		cs_n <= 1'b1;
		sdi <= ~tx[0];
		half();
	endtask
endmodule
`default_nettype wire

// file: test/config_parity_and_output_select_tb.sv
// Self-checking bench for the parity alert and output select block.
`timescale 1ns/100ps
`default_nettype none
module config_parity_and_output_select_tb;
	import cfg_parity_pkg::*;
	logic             mclk, nrst, cs_n_pin, sclk_pin, sdi_pin;
	logic             carrier_pin, demod_pin, signal_present_pin;
	out_gate_s        gate_in;
	logic             alert_o, alert_oe, lf_o, lf_oe;
	logic             rssi_enable, active_mode, timers_enable;
	logic [REG_W-1:0] status_reg;
	logic [7:0]       cfg [NUM_CFG];
	int               mismatches, checks, n;
	cfg_parity_out_sel #(.AGC_CYC(4)) DUT (.mclk(mclk), .nrst(nrst), .cs_n_pin(cs_n_pin),
		.sclk_pin(sclk_pin), .sdi_pin(sdi_pin), .carrier_pin(carrier_pin), .demod_pin(demod_pin),
		.signal_present_pin(signal_present_pin), .gate_in(gate_in), .alert_o(alert_o),
		.alert_oe(alert_oe), .lf_output_pin_o(lf_o), .lf_output_pin_oe(lf_oe),
		.rssi_enable(rssi_enable), .active_mode(active_mode), .timers_enable(timers_enable),
		.status_reg(status_reg));
	// A released data pin has no pull, so the host sees the inverse of the last value.
	spi_host_model host (.mclk(mclk), .sdo(lf_o ^ lf_oe), .cs_n(cs_n_pin), .sclk(sclk_pin), .sdi(sdi_pin));
	task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
		checks++;
		if (got !== exp) begin
			mismatches++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic wt(input int c);
		repeat (c) @(posedge mclk);
	endtask
	function automatic logic [7:0] colp();
		logic [7:0] c;
		for (int j = 0; j < 8; j++)
			c[j] = ~^{cfg[0][j], cfg[1][j], cfg[2][j], cfg[3][j], cfg[4][j], cfg[5][j]};
		return c;
	endfunction
	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		host.frame({CMD_WRITE, a, d, ~^d});
	endtask
	task automatic setc(input int a, input logic [7:0] d);
		cfg[a] = d;
		wr(a[3:0], d);
		wr(ADDR_COLPAR, colp());
		wt(3);
	endtask
	task automatic rd(input logic [3:0] a, input logic [15:0] exp);
		host.frame({CMD_READ, a, 9'h000});
		host.frame(16'h0000);
		cmp(host.rx, exp);
	endtask
	task automatic run();
		logic p;
		n = 0;
		p = lf_o;
		for (int i = 0; i < 256; i++) begin
			carrier_pin <= i[3];
			@(posedge mclk);
			n += int'(lf_o & ~p);
			p = lf_o;
		end
	endtask
	task automatic t_program();
		cmp(alert_oe, 1'b0);
		cmp(status_reg[1], 1'b1);
		cfg = '{8'h01, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
		for (int a = 0; a < NUM_CFG; a++)
			wr(a[3:0], cfg[a]);
		wt(3);
		cmp(alert_oe, 1'b0);
		wr(ADDR_COLPAR, colp());
		wt(3);
		cmp(alert_oe, 1'b1);
		wr(ADDR_STATUS, 8'hff);
		wt(3);
		cmp(alert_oe, 1'b1);
		rd(ADDR_COLPAR, {7'h00, colp(), ~^colp()});
		rd(ADDR_CFG0, {7'h00, 8'h01, 1'b0});
	endtask
	task automatic t_demod();
		host.frame({CMD_WRITE, ADDR_CFG2, 8'h00, 1'b0});
		wt(3);
		cmp(alert_oe, 1'b0);
		for (int i = 0; i < 2; i++) begin
			demod_pin <= i[0];
			wt(8);
			cmp({lf_oe, lf_o}, {1'b0, i[0]});
		end
		setc(2, 8'h00);
		cmp(alert_oe, 1'b1);
		setc(0, 8'h00);
		cmp(lf_oe, 1'b1);
		setc(0, 8'h01);
	endtask
	task automatic t_carrier_clock_output();
		setc(1, 8'h40);
		run();
		cmp(n >= 15, 1'b1);
		gate_in <= 3'b011;
		run();
		cmp(n == 0, 1'b1);
		gate_in <= 3'b111;
		signal_present_pin <= 1'b0;
		wt(4);
		signal_present_pin <= 1'b1;
		wt(2);
		cmp({status_reg[4], lf_o}, 2'b00);
		wt(8);
		cmp({status_reg[4], lf_o}, 2'b11);
		setc(2, 8'h40);
		run();
		cmp(n inside {[3:4]}, 1'b1);
		setc(2, 8'h00);
	endtask
	task automatic t_rssi();
		for (int t = 2; t < 4; t++) begin
			setc(1, {t[1:0], 6'h00});
			cmp({rssi_enable, active_mode, timers_enable}, 3'b110);
		end
		rd(ADDR_CFG1, {7'h00, 8'hc0, 1'b1});
		wt(8);
		cmp(rssi_enable, 1'b1);
		cmp(status_reg[4], 1'b0);
		signal_present_pin <= 1'b0;
		wt(4);
		cmp(active_mode, 1'b1);
		setc(1, 8'h00);
		cmp({rssi_enable, active_mode, timers_enable}, 3'b001);
		signal_present_pin <= 1'b1;
	endtask
	task automatic end_of_test();
		$display("checks %0d mismatches %0d", checks, mismatches);
		if (mismatches == 0 && checks > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	initial begin
		mclk = 1'b0;
		forever #2 mclk = ~mclk;
	end
	initial begin
		nrst = 1'b0;
		carrier_pin = 1'b0;
		demod_pin = 1'b0;
		signal_present_pin = 1'b1;
		gate_in = 3'b111;
		mismatches = 0;
		checks = 0;
		wt(10);
		nrst <= 1'b1;
		wt(4);
		t_program();
		t_demod();
		t_carrier_clock_output();
		t_rssi();
		end_of_test();
	end
endmodule
`default_nettype wire
